// ---- rtl/utdesc_map.vh ----
/*
  control word field positions, status bits and register offsets
  for the descriptor error and speed control block.
  assumes inclusion by bare name from rtl design files.
*/
`ifndef UTDESC_MAP_VH
`define UTDESC_MAP_VH

// control-and-status word fields
`define UTD_RSV_HI 31
`define UTD_RSV_LO 30
`define UTD_SPD_BIT 29
`define UTD_CNT_HI 28
`define UTD_CNT_LO 27
`define UTD_SLOW_BIT 26
`define UTD_ACT_BIT 23
`define UTD_STALL_BIT 22
`define UTD_DBE_BIT 21
`define UTD_BAB_BIT 20
`define UTD_NAK_BIT 19
`define UTD_CRC_BIT 18
`define UTD_BSTF_BIT 17

// register byte offsets
`define UTD_OFF_CTRL 8'h00
`define UTD_OFF_WORD_IN 8'h04
`define UTD_OFF_RESULT 8'h08
`define UTD_OFF_WORD_OUT 8'h0C
`define UTD_OFF_STATUS 8'h10

// control register bits
`define UTD_CTL_CRCTO_EN 0
`define UTD_CTL_IE 1

// status register bits
`define UTD_ST_FRAME_INT 0
`define UTD_ST_IRQ 1
`define UTD_ST_SHORT 2
`define UTD_ST_QH_HOLD 3
`define UTD_ST_PREAMBLE 4
`define UTD_ST_SLOW 5
`define UTD_ST_BUSY 6

// result register bits
`define UTD_RES_DONE 0
`define UTD_RES_IN 1
`define UTD_RES_QUEUED 2
`define UTD_RES_SHORT 3
`define UTD_RES_CRC 4
`define UTD_RES_TMO 5
`define UTD_RES_DBE 6
`define UTD_RES_BSTF 7
`define UTD_RES_NAK 8
`define UTD_RES_STALL 9
`define UTD_RES_BAB 10
`define UTD_RES_PORT_SLOW 11
`define UTD_RES_FRAME_END 12

`define UTD_RESP_OKAY 2'h0
`define UTD_RESP_SLVERR 2'h2

`endif

// ---- rtl/utdesc_ctrl.v ----
/*
  descriptor control word interpreter: short packet, error down counter,
  stall and interrupt outcome, low speed preamble choice; axi4-lite slave.
  assumes the schedule engine hands each transaction outcome through the
  result register, and reads the updated word back afterwards.
*/
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "utdesc_map.vh"

// Functional notes
// - short input in queue: inactive, hold head, flag
// - short packet interrupt only enabled, at frame end
// - any error suppresses short packet report
// - counting error decrements nonzero count, written back
// - one to zero: inactive, stalled, error bit
// - interrupt on zero by buffer/stuff, optionally crc/timeout
// - count zero means unlimited retries
// - crc, timeout, buffer, stuff count; nak does not
// - babble or stall deactivates, count unchanged
// - slow bit selects low speed target
// - low speed on full speed port: preamble
// - low speed on low speed port: no preamble
// - active cleared on completion or stall
module utdesc_ctrl (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // port signalling
  output reg preamble_send,
  output reg slow_device_select,
  output reg frame_interrupt_flag,
  output reg irq
);

  reg [31:0] word_in_reg;
  reg [31:0] word_out_reg;
  reg [12:0] result_reg;
  reg [1:0] ctrl_reg;
  reg [6:0] status_reg;
  reg aw_hold_reg;
  reg [7:0] aw_addr_reg;
  reg w_hold_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg busy_reg;

  // merge write strobes into an old word
  function [31:0] strb_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer i;
    begin
      strb_merge = old_v;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          strb_merge[i*8 +: 8] = new_v[i*8 +: 8];
    end
  endfunction

  // is the offset mapped
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `UTD_OFF_CTRL) || (a == `UTD_OFF_WORD_IN) || (a == `UTD_OFF_RESULT) ||
        (a == `UTD_OFF_WORD_OUT) || (a == `UTD_OFF_STATUS);
    end
  endfunction

  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire aw_ok = aw_hold_reg || (s_axi_awvalid && s_axi_awready);
  wire w_ok = w_hold_reg || (s_axi_wvalid && s_axi_wready);
  wire [7:0] wa = aw_hold_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wd = w_hold_reg ? w_data_reg : s_axi_wdata;
  wire [3:0] ws = w_hold_reg ? w_strb_reg : s_axi_wstrb;
  wire wr_go = aw_ok && w_ok && !s_axi_bvalid;
  wire [31:0] res_new = strb_merge({19'h00000, result_reg}, wd, ws);
  wire res_go = wr_go && (wa == `UTD_OFF_RESULT) && res_new[`UTD_RES_DONE];
  wire st_clr = wr_go && (wa == `UTD_OFF_STATUS);

  // outcome evaluation of one transaction
  wire [31:0] w = word_in_reg;
  wire [1:0] cnt = w[`UTD_CNT_HI:`UTD_CNT_LO];
  wire e_crc = res_new[`UTD_RES_CRC];
  wire e_tmo = res_new[`UTD_RES_TMO];
  wire e_dbe = res_new[`UTD_RES_DBE];
  wire e_bstf = res_new[`UTD_RES_BSTF];
  wire e_stall = res_new[`UTD_RES_STALL];
  wire e_bab = res_new[`UTD_RES_BAB];
  wire e_nak = res_new[`UTD_RES_NAK];
  wire e_cnt = e_crc | e_tmo | e_dbe | e_bstf;
  wire e_fatal = e_stall | e_bab;
  wire e_any = e_cnt | e_fatal;
  wire short_hit = w[`UTD_SPD_BIT] && res_new[`UTD_RES_IN] && res_new[`UTD_RES_QUEUED] &&
    res_new[`UTD_RES_SHORT] && !e_any && !e_nak;
  wire do_dec = e_cnt && !e_fatal && (cnt != 2'h0);
  wire [1:0] cnt_dec = cnt - 2'h1;
  wire to_zero = do_dec && (cnt == 2'h1);
  wire zero_irq = to_zero && (e_dbe || e_bstf || ((e_crc || e_tmo) && ctrl_reg[`UTD_CTL_CRCTO_EN]));
  wire ok_done = !e_any && !e_nak;

  reg [31:0] upd;
  always @*
  begin
    upd = w;
    upd[`UTD_RSV_HI:`UTD_RSV_LO] = 2'h0;
    if (do_dec)
      upd[`UTD_CNT_HI:`UTD_CNT_LO] = cnt_dec;
    if (e_crc)
      upd[`UTD_CRC_BIT] = 1'b1;
    if (e_tmo)
      upd[`UTD_CRC_BIT] = 1'b1;
    if (e_dbe)
      upd[`UTD_DBE_BIT] = 1'b1;
    if (e_bstf)
      upd[`UTD_BSTF_BIT] = 1'b1;
    if (e_nak)
      upd[`UTD_NAK_BIT] = 1'b1;
    if (e_bab)
      upd[`UTD_BAB_BIT] = 1'b1;
    if (e_fatal || to_zero)
    begin
      upd[`UTD_STALL_BIT] = 1'b1;
      upd[`UTD_ACT_BIT] = 1'b0;
    end
    if (ok_done || short_hit)
      upd[`UTD_ACT_BIT] = 1'b0;
  end

  // pending interrupt causes, delivered at frame end
  reg pend_reg;
  wire frame_end = res_go && res_new[`UTD_RES_FRAME_END];
  wire cause_hit = res_go && (short_hit || zero_irq);
  wire pend_set = cause_hit || pend_reg;
  wire [31:0] ctrl_new = strb_merge({30'h00000000, ctrl_reg}, wd, ws);
  wire port_slow_now = result_reg[`UTD_RES_PORT_SLOW];

  // write channels: hold whichever of address and data came first
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UTD_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready && !wr_go)
      begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !wr_go)
      begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wa) ? `UTD_RESP_OKAY : `UTD_RESP_SLVERR;
      end
    end
  end

  // software written registers and outcome write back
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      word_in_reg <= 32'h00000000;
      word_out_reg <= 32'h00000000;
      result_reg <= 13'h0000;
      ctrl_reg <= 2'h0;
    end
    else
    begin
      if (wr_go && (wa == `UTD_OFF_CTRL))
        ctrl_reg <= ctrl_new[1:0];
      if (wr_go && (wa == `UTD_OFF_WORD_IN))
        word_in_reg <= strb_merge(word_in_reg, wd, ws);
      if (wr_go && (wa == `UTD_OFF_RESULT))
        result_reg <= {res_new[12:1], 1'b0};
      if (res_go)
        word_out_reg <= upd;
    end
  end

  // speed select and preamble from loaded word and stored port state
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      preamble_send <= 1'b0;
      slow_device_select <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      slow_device_select <= w[`UTD_SLOW_BIT];
      preamble_send <= w[`UTD_SLOW_BIT] && !port_slow_now && w[`UTD_ACT_BIT];
      busy_reg <= w[`UTD_ACT_BIT];
    end
  end

  // status flags, pending cause and interrupt outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_reg <= 7'h00;
      pend_reg <= 1'b0;
      frame_interrupt_flag <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      // hardware set wins over write-one-to-clear
      if (st_clr)
        status_reg <= status_reg & ~wd[6:0];
      if (res_go)
      begin
        status_reg[`UTD_ST_SHORT] <= short_hit;
        status_reg[`UTD_ST_QH_HOLD] <= short_hit;
      end
      status_reg[`UTD_ST_PREAMBLE] <= preamble_send;
      status_reg[`UTD_ST_SLOW] <= slow_device_select;
      status_reg[`UTD_ST_BUSY] <= busy_reg;
      if (frame_end)
      begin
        pend_reg <= 1'b0;
        if (pend_set)
        begin
          status_reg[`UTD_ST_FRAME_INT] <= 1'b1;
          if (ctrl_reg[`UTD_CTL_IE])
            status_reg[`UTD_ST_IRQ] <= 1'b1;
        end
      end
      else if (cause_hit)
        pend_reg <= 1'b1;
      frame_interrupt_flag <= status_reg[`UTD_ST_FRAME_INT];
      irq <= status_reg[`UTD_ST_IRQ];
    end
  end

  // read channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `UTD_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end
    else
    begin
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? `UTD_RESP_OKAY : `UTD_RESP_SLVERR;
        case (s_axi_araddr)
          `UTD_OFF_CTRL: s_axi_rdata <= {30'h00000000, ctrl_reg};
          `UTD_OFF_WORD_IN: s_axi_rdata <= word_in_reg;
          `UTD_OFF_RESULT: s_axi_rdata <= {19'h00000, result_reg};
          `UTD_OFF_WORD_OUT: s_axi_rdata <= word_out_reg;
          `UTD_OFF_STATUS: s_axi_rdata <= {25'h0000000, status_reg};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- dv/utd_chk.sv ----
/*
  bus and port outcome assertions for the descriptor control block.
  assumes the top module ports only, one clock, sync active low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module utd_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port signalling
  input wire logic preamble_send,
  input wire logic slow_device_select,
  input wire logic frame_interrupt_flag,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  reset_quiet_a: assert property (disable iff (1'b0) !aresetn |=> !irq && !preamble_send && !s_axi_bvalid)
    else $error("outputs not cleared by reset");
  preamble_slow_a: assert property (preamble_send |-> slow_device_select) else $error("preamble for full speed");
  irq_cause_a: assert property ($rose(irq) |-> $past(s_axi_bvalid)) else $error("irq without frame end write");
  flag_cause_a: assert property ($rose(frame_interrupt_flag) |-> $past(s_axi_bvalid))
    else $error("frame flag without write");
endmodule
bind utdesc_ctrl utd_chk utd_chk_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .preamble_send(preamble_send), .slow_device_select(slow_device_select),
  .frame_interrupt_flag(frame_interrupt_flag), .irq(irq));
`default_nettype wire

// ---- dv/utd_port.sv ----
/*
  root port device model: reports its speed, records preambles seen.
  assumes the bench sets the attached speed between transactions.
*/
`timescale 1ns/1ns
`default_nettype none
module utd_port (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // attached device
  input wire logic attach_slow,
  input wire logic preamble_send,
  output logic port_slow,
  output logic pre_seen
);
  assign port_slow = attach_slow;
  always @(posedge aclk)
  begin
    if (!aresetn)
      pre_seen <= 1'b0;
    else if (preamble_send)
      pre_seen <= 1'b1;
  end
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
/*
  register level bench for the descriptor control block.
  assumes the bound checker and the root port device model.
*/
`timescale 1ns/1ns
`default_nettype none
`include "utdesc_map.vh"
module tb;
  localparam logic [31:0] ACT = 32'h1 << `UTD_ACT_BIT, STL = 32'h1 << `UTD_STALL_BIT, CRC = 32'h1 << `UTD_CRC_BIT;
  localparam logic [31:0] DBE = 32'h1 << `UTD_DBE_BIT, SHORT_DETECT_ENABLE = 32'h1 << `UTD_SPD_BIT, C1 = 32'h1 << `UTD_CNT_LO;
  localparam logic [31:0] RSV = 32'hC0000000, SLW = 32'h1 << `UTD_SLOW_BIT, MSK = RSV | 3 * C1 | ACT | STL;
  localparam logic [31:0] DN = 32'h1, IQS = 32'hE, FE = 32'h1000;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, attach_slow = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  wire awready, wready, bvalid, arready, rvalid, pre, sds, fint, irq, port_slow, pre_seen;
  logic [31:0] got;
  int err_count = 0, n_checks = 0, tn = 0;
  always #4 aclk = ~aclk;
  utdesc_ctrl utdesc_ctrl_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .preamble_send(pre), .slow_device_select(sds), .frame_interrupt_flag(fint), .irq(irq));
  utd_port utd_port_i (.aclk(aclk), .aresetn(aresetn), .attach_slow(attach_slow), .preamble_send(pre),
    .port_slow(port_slow), .pre_seen(pre_seen));
  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb_;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    tb_ = 0;
    while (!tb_)
    begin
      @(negedge aclk);
      ta = awv && awready;
      tw = wv && wready;
      tb_ = bvalid;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    tr = 0;
    while (!tr)
    begin
      @(negedge aclk);
      ta = arv && arready;
      tr = rvalid;
      got = rdata;
      @(posedge aclk);
      if (ta) arv <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic tc(input logic [1:0] c, input logic [31:0] w, r, e, input logic [2:0] s);
    wr(`UTD_OFF_CTRL, {30'h0, c});
    wr(`UTD_OFF_WORD_IN, w);
    wr(`UTD_OFF_RESULT, r);
    rd(`UTD_OFF_WORD_OUT);
    ck("word_out", e, got & (MSK | e));
    rd(`UTD_OFF_STATUS);
    ck("status", {29'h0, s}, got & 32'h7);
    ck("qh_hold", {31'h0, s[2]}, {31'h0, got[3]});
    ck("irq", {31'h0, s[1]}, {31'h0, irq});
    ck("frame_flag", {31'h0, s[0]}, {31'h0, fint});
    wr(`UTD_OFF_STATUS, 32'h7F);
    tn++;
    $display("test %0d done", tn);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    err_count++;
    close_out;
  end
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    tc(2'h3, RSV | ACT | C1, DN | 32'h10 | FE, STL | CRC, 3'h3);
    tc(2'h2, ACT | C1, DN | 32'h40 | FE, STL | DBE, 3'h3);
    tc(2'h0, ACT | 3 * C1, DN | 32'h40, ACT | 2 * C1, 3'h0);
    tc(2'h0, ACT | 2 * C1, DN | 32'h20, ACT | C1, 3'h0);
    tc(2'h0, ACT | 2 * C1, DN | 32'h80, ACT | C1, 3'h0);
    tc(2'h0, ACT | C1, DN | 32'h100, ACT | C1, 3'h0);
    tc(2'h0, ACT, DN | 32'h80, ACT, 3'h0);
    tc(2'h0, ACT | 2 * C1, DN | 32'h400, STL | 2 * C1, 3'h0);
    tc(2'h0, ACT | 2 * C1, DN | 32'h200, STL | 2 * C1, 3'h0);
    tc(2'h2, SHORT_DETECT_ENABLE | ACT | 3 * C1, DN | IQS | FE, 3 * C1, 3'h7);
    tc(2'h0, SHORT_DETECT_ENABLE | ACT | 3 * C1, DN | IQS | FE, 3 * C1, 3'h5);
    tc(2'h2, SHORT_DETECT_ENABLE | ACT | 3 * C1, DN | IQS | 32'h400 | FE, STL | 3 * C1, 3'h0);
    tc(2'h2, ACT | C1, DN | 32'h10 | FE, STL | CRC, 3'h0);
    attach_slow <= 1'b1;
    @(posedge aclk);
    wr(`UTD_OFF_RESULT, {20'h0, port_slow, 11'h0});
    wr(`UTD_OFF_WORD_IN, ACT | SLW);
    repeat (2) @(negedge aclk);
    ck("slow_select", 32'h1, {31'h0, sds});
    ck("no_preamble", 32'h0, {31'h0, pre_seen});
    @(posedge aclk);
    attach_slow <= 1'b0;
    @(posedge aclk);
    wr(`UTD_OFF_RESULT, {20'h0, port_slow, 11'h0});
    repeat (2) @(negedge aclk);
    ck("preamble", 32'h3, {30'h0, pre, pre_seen});
    @(posedge aclk);
    wr(`UTD_OFF_WORD_IN, ACT);
    repeat (2) @(negedge aclk);
    ck("full_speed", 32'h0, {30'h0, sds, pre});
    @(posedge aclk);
    rd(8'h20);
    ck("unmapped_rresp", {30'h0, `UTD_RESP_SLVERR}, {30'h0, rresp});
    ck("unmapped_rdata", 32'h0, got);
    wr(8'h20, 32'h0);
    ck("unmapped_bresp", {30'h0, `UTD_RESP_SLVERR}, {30'h0, bresp});
    $display("test %0d done", tn + 1);
    close_out;
  end
endmodule
`default_nettype wire
